//--- rtl/hvac_defrost_sequencer.sv
/*
  Defrost and recovery sequencer: evaporator defrost, freeze protection,
  heat pump demand and timed defrost, soft start and staged auxiliary heat.
  Assumes pins are asynchronous, controller inputs share sys_clk_in,
  temperatures in whole degrees F and zone temperature in tenths.
*/
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "hvac_defrost_cfg.svh"
module hvac_defrost_sequencer
  import hvac_defrost_pkg::*;
#(
  parameter int HALF_CYCLES = `HALF_SEC_NS / `CLK_PERIOD_NS,
  parameter int SW = 13
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Unit pins, asynchronous
  input wire logic freeze_closed_in,
  input wire logic defrost_temp_switch_in,
  input wire logic [1:0] hp_ctrl_open_in,
  input wire logic emerg_heat_in,
  input wire logic dfm_link_ok_in,
  input wire logic [1:0] interval_sel_in,
  input wire logic demand_cfg_in,
  input wire logic dual_fan_cfg_in,
  // Controller logic
  input wire logic cool_call_in,
  input wire logic heat_call_in,
  input wire logic [1:0] comp_req_in,
  input wire logic signed [7:0] outdoor_temp_in,
  input wire logic signed [7:0] coil_temp_in,
  input wire logic signed [9:0] zone_temp_in,
  input wire logic coil_sensor_fail_in,
  input wire logic outdoor_air_sensor_fail_in,
  input wire logic econ_cmd_in,
  // Relay and indicator outputs
  output logic [1:0] comp_on_out,
  output logic indoor_fan_force_out,
  output logic supply_fan_force_out,
  output logic outdoor_fan_on_out,
  output logic switchover_valve_out,
  output logic [1:0] aux_stage_out,
  output logic econ_cmd_out,
  output logic heat_fail_out,
  output logic cool_fail_out,
  output logic heat_led_out,
  output logic cool_led_out
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [SW-1:0] secs(input int s);
    secs = SW'(s);
  endfunction
  function automatic logic [SW-1:0] mins(input int m);
    mins = SW'(m * `SEC_PER_MIN);
  endfunction
  function automatic logic signed [8:0] degf(input int f);
    degf = 9'(f);
  endfunction
  function automatic logic [SW-1:0] sinc(input logic [SW-1:0] v);
    sinc = (&v) ? v : v + 1'b1;
  endfunction

  logic half_tick, sec_tick;
  hvac_timebase #(.HALF_CYCLES(HALF_CYCLES)) u_tb (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .half_tick_out(half_tick),
    .sec_tick_out(sec_tick)
  );

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NP = 10;
  logic [NP-1:0] s1_q, s2_q, s3_q, pin_q;
  logic frz_closed, dt_closed, emerg, link_ok, demand, dual;
  logic [1:0] hp_open, sel;
  // A bit changes only once stages two and three agree
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= {freeze_closed_in, defrost_temp_switch_in, hp_ctrl_open_in, emerg_heat_in,
               dfm_link_ok_in, interval_sel_in, demand_cfg_in, dual_fan_cfg_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end
  assign {frz_closed, dt_closed, hp_open, emerg, link_ok, sel, demand, dual} = pin_q;

  wire signed [8:0] outdoor_temp = {outdoor_temp_in[7], outdoor_temp_in};
  wire signed [8:0] ct = {coil_temp_in[7], coil_temp_in};
  wire signed [8:0] delta = outdoor_temp - ct; // Outdoor minus coil, always live

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] ctrl_q;
  logic evap_act_q, trip_q, dd_fault_q, learned_q;
  logic [1:0] aux_q;
  hp_state_t hp_q;
  wire tt_lost = ~demand & ~link_ok;
  // Control holds installed auxiliary stage count
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) ctrl_q <= `CTRL_RST;
    else if (reg_wr_in && reg_addr_in == `REG_CTRL) ctrl_q <= reg_wdata_in;
  end
  // Read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) reg_rdata_out <= 8'h00;
    else if (!reg_rd_in) reg_rdata_out <= 8'h00;
    else if (reg_addr_in == `REG_CTRL) reg_rdata_out <= ctrl_q;
    else if (reg_addr_in == `REG_STAT)
      reg_rdata_out <= {learned_q, aux_q, tt_lost, trip_q, dd_fault_q, hp_q != HP_IDLE, evap_act_q};
    else reg_rdata_out <= 8'h00;
  end

  // ****************************************************************
  // Compressor gating
  // ****************************************************************
  logic [SW-1:0] run_s_q [2];
  logic [1:0] stop_q;
  wire [1:0] frz_block = {2{trip_q}} & (stop_q | ~comp_on_out);
  wire mech_block = evap_act_q | (heat_call_in & emerg); // Emergency heat locks out compressors
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) comp_on_out <= 2'h0;
    else comp_on_out <= comp_req_in & ~frz_block & ~{2{mech_block}};
  end
  // Continuous run seconds per compressor
  for (genvar i = 0; i < 2; i++) begin : g_run
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) run_s_q[i] <= '0;
      else if (!comp_on_out[i]) run_s_q[i] <= '0;
      else if (sec_tick) run_s_q[i] <= sinc(run_s_q[i]);
    end
  end

  // ****************************************************************
  // Evaporator defrost
  // ****************************************************************
  logic [SW-1:0] evap_acc_q, evap_t_q;
  wire low_amb = outdoor_temp < (dual ? degf(`AMB_DUAL_F) : degf(`AMB_SINGLE_F));
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      evap_act_q <= 1'b0;
      evap_acc_q <= '0;
      evap_t_q <= '0;
    end else if (evap_act_q) begin
      if (evap_t_q >= mins(`EVAP_DEF_MIN)) begin
        evap_act_q <= 1'b0; // Resume and restart the count
        evap_acc_q <= '0;
      end else if (sec_tick) evap_t_q <= evap_t_q + 1'b1;
    end else if (evap_acc_q >= mins(`EVAP_RUN_MIN)) begin
      evap_act_q <= 1'b1;
      evap_t_q <= '0;
    end else if (sec_tick && cool_call_in && |comp_on_out && low_amb)
      evap_acc_q <= evap_acc_q + 1'b1;
  end
  // Indoor fan kept running through the defrost
  assign indoor_fan_force_out = evap_act_q;
  // Economizer path is a plain register, defrost never touches it
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) econ_cmd_out <= 1'b0;
    else econ_cmd_out <= econ_cmd_in;
  end

  // ****************************************************************
  // Freeze protection
  // ****************************************************************
  logic [SW-1:0] open_s_q, closed_s_q, sat_s_q;
  wire frz_release = closed_s_q >= secs(`FRZ_DEB_S) && sat_s_q >= secs(`FRZ_SAT_S); // Longer wins
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      open_s_q <= '0;
      closed_s_q <= '0;
      sat_s_q <= '0;
    end else begin
      if (frz_closed) open_s_q <= '0;
      else if (sec_tick) open_s_q <= sinc(open_s_q);
      if (!frz_closed) closed_s_q <= '0;
      else if (sec_tick) closed_s_q <= sinc(closed_s_q);
      if (cool_call_in) sat_s_q <= '0;
      else if (sec_tick) sat_s_q <= sinc(sat_s_q);
    end
  end
  // Trip latch; each compressor stops once past its minimum run
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trip_q <= 1'b0;
      stop_q <= 2'h0;
    end else if (!trip_q) begin
      trip_q <= open_s_q >= secs(`FRZ_DEB_S);
      stop_q <= 2'h0;
    end else if (frz_release) begin
      trip_q <= 1'b0;
      stop_q <= 2'h0;
    end else begin
      stop_q <= stop_q | {run_s_q[1] >= mins(`FRZ_MIN_RUN_MIN), run_s_q[0] >= mins(`FRZ_MIN_RUN_MIN)};
    end
  end
  assign supply_fan_force_out = trip_q;

  // ****************************************************************
  // Heat pump defrost
  // ****************************************************************
  logic [SW-1:0] hp_run_q, hp_t_q, low_s_q, interval;
  logic signed [8:0] init_q;
  logic [3:0] tcnt_q;
  logic [4:0] hcnt_q;
  logic hp_start;
  wire heating = heat_call_in & ~cool_call_in & ~emerg;
  wire permit = outdoor_temp < degf(`DD_ODT_MAX_F) && ct < degf(`DD_CT_MAX_F);
  wire fallback = demand ? dd_fault_q : tt_lost;
  wire timed = hp_t_q >= mins(`DEF_MAX_MIN);
  wire dtt_hit = ct >= outdoor_temp + degf(`DD_TERM_ADD_F);
  wire early = (~demand & |hp_open) | (~fallback & (demand ? dtt_hit : ~dt_closed));
  wire end_ev = (hp_q == HP_DEFR) && (timed || early);
  wire done_ev = (hp_q == HP_SOFT) && hp_t_q >= secs(`SOFT_S);
  // Selector decode
  always_comb begin
    unique case (sel)
      2'h0: interval = mins(`TT_SEL0_MIN);
      2'h1: interval = mins(`TT_SEL1_MIN);
      2'h2: interval = mins(`TT_SEL2_MIN);
      2'h3: interval = mins(`TT_SEL3_MIN);
    endcase
  end
  // Start condition per method
  always_comb begin
    if (fallback) hp_start = hp_run_q >= (demand ? mins(`FB_RUN_MIN) : mins(`LINK_RUN_MIN));
    else if (demand)
      hp_start = learned_q ? (permit && delta > init_q) : (permit && hp_run_q >= mins(`DD_INIT_MIN));
    else hp_start = hp_run_q >= interval && dt_closed;
  end
  // Heating run time; cooling changeover restarts it
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) hp_run_q <= '0;
    else if (cool_call_in || hp_q != HP_IDLE) hp_run_q <= '0;
    else if (sec_tick && heating && |comp_on_out) hp_run_q <= sinc(hp_run_q);
  end
  // Defrost phases; soft start holds the valve with the outdoor fan on
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hp_q <= HP_IDLE;
      hp_t_q <= '0;
    end else begin
      unique case (hp_q)
        HP_IDLE: if (heating && hp_start) begin
          hp_q <= HP_DEFR;
          hp_t_q <= '0;
        end
        HP_DEFR: if (end_ev) begin
          hp_q <= HP_SOFT;
          hp_t_q <= '0;
        end else if (sec_tick) hp_t_q <= hp_t_q + 1'b1; // Timeout covers a stuck switch
        HP_SOFT: if (done_ev) hp_q <= HP_IDLE;
        else if (sec_tick) hp_t_q <= hp_t_q + 1'b1;
        default: hp_q <= HP_IDLE;
      endcase
    end
  end
  assign switchover_valve_out = hp_q != HP_IDLE;
  assign outdoor_fan_on_out = hp_q == HP_SOFT;

  // Demand learning and fault detection; fault holds until reset
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dd_fault_q <= 1'b0;
      learned_q <= 1'b0;
      init_q <= '0;
      tcnt_q <= '0;
      hcnt_q <= '0;
      low_s_q <= '0;
    end else if (demand && !dd_fault_q) begin
      if (coil_sensor_fail_in || outdoor_air_sensor_fail_in) dd_fault_q <= 1'b1;
      if (end_ev) begin
        tcnt_q <= (timed && !dtt_hit) ? tcnt_q + 1'b1 : '0;
        if (timed && !dtt_hit && tcnt_q == 4'(`DD_TIMED_MAX - 1)) dd_fault_q <= 1'b1;
      end
      if (done_ev && !learned_q) begin
        learned_q <= 1'b1; // Clean coil delta sampled after first cycle
        init_q <= delta + degf(`DD_MARGIN_F);
      end else if (done_ev) begin
        hcnt_q <= (delta > init_q) ? hcnt_q + 1'b1 : '0;
        if (delta > init_q && hcnt_q == 5'(`DD_HIGH_MAX - 1)) dd_fault_q <= 1'b1;
      end
      if (!(heating && |comp_on_out && learned_q && delta < degf(`DD_LOW_DELTA_F))) low_s_q <= '0;
      else if (low_s_q >= secs(`DD_LOW_HR * `SEC_PER_HR)) dd_fault_q <= 1'b1;
      else if (sec_tick) low_s_q <= low_s_q + 1'b1;
    end
  end

  // ****************************************************************
  // Failure indication
  // ****************************************************************
  logic blink_q, fail_heat_q, fail_cool_q;
  // Link loss blinks at one flash a second
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      blink_q <= 1'b0;
      fail_heat_q <= 1'b0;
      fail_cool_q <= 1'b0;
    end else begin
      blink_q <= tt_lost & (blink_q ^ half_tick);
      fail_heat_q <= emerg | (demand & dd_fault_q) | tt_lost;
      fail_cool_q <= (demand & dd_fault_q) | tt_lost;
    end
  end
  assign heat_fail_out = fail_heat_q;
  assign cool_fail_out = fail_cool_q;
  assign heat_led_out = fail_heat_q & (~tt_lost | blink_q);
  assign cool_led_out = fail_cool_q & (~tt_lost | blink_q);

  // ****************************************************************
  // Smart recovery staging
  // ****************************************************************
  logic [SW-1:0] sr_t_q;
  logic signed [9:0] snap_q;
  wire mech = heat_call_in & ~emerg & |comp_on_out;
  wire sr_check = mech && sr_t_q >= mins(`SR_CHECK_MIN);
  wire rising = (zone_temp_in - snap_q) >= 10'sd`SR_RISE_TENTHS;
  wire [1:0] inst = ctrl_q[`CTRL_AUX_F];
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sr_t_q <= '0;
      snap_q <= '0;
      aux_q <= 2'h0;
    end else if (heat_call_in && emerg) begin
      aux_q <= inst; // Auxiliary heat only
      sr_t_q <= '0;
    end else if (!mech) begin
      aux_q <= 2'h0;
      sr_t_q <= '0;
      snap_q <= zone_temp_in;
    end else if (sr_check) begin
      sr_t_q <= '0;
      snap_q <= zone_temp_in;
      if (rising && aux_q != 2'h0) aux_q <= aux_q - 1'b1; // Highest stage first
      else if (!rising && aux_q < inst) aux_q <= aux_q + 1'b1;
    end else if (sec_tick) sr_t_q <= sr_t_q + 1'b1;
  end
  assign aux_stage_out = {aux_q >= 2'h2, aux_q >= 2'h1};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_evap_start;
    $rose(evap_act_q) |-> $past(evap_acc_q) >= mins(`EVAP_RUN_MIN);
  endproperty
  a_evap_start: assert property (p_evap_start) else $error("evap defrost early");
  property p_evap_off;
    evap_act_q ##1 evap_act_q |-> comp_on_out == 2'h0 && indoor_fan_force_out;
  endproperty
  a_evap_off: assert property (p_evap_off) else $error("compressor on in evap defrost");
  property p_evap_end;
    $fell(evap_act_q) |-> evap_acc_q == '0 && $past(evap_t_q) == mins(`EVAP_DEF_MIN);
  endproperty
  a_evap_end: assert property (p_evap_end) else $error("evap defrost length wrong");
  property p_econ;
    econ_cmd_out == $past(econ_cmd_in);
  endproperty
  a_econ: assert property (p_econ) else $error("economizer altered");
  property p_trip;
    $rose(trip_q) |-> !$past(frz_closed, 2) && $past(open_s_q) >= secs(`FRZ_DEB_S);
  endproperty
  a_trip: assert property (p_trip) else $error("freeze trip early");
  property p_fan_rel;
    $fell(supply_fan_force_out) |-> $past(closed_s_q) >= secs(`FRZ_DEB_S) && $past(sat_s_q) >= secs(`FRZ_SAT_S);
  endproperty
  a_fan_rel: assert property (p_fan_rel) else $error("supply fan released early");
  property p_soft;
    $fell(switchover_valve_out) |-> $past(outdoor_fan_on_out) && $past(hp_t_q) >= secs(`SOFT_S);
  endproperty
  a_soft: assert property (p_soft) else $error("valve dropped without soft start");
  property p_emerg;
    heat_call_in && emerg |=> comp_on_out == 2'h0 ##1 heat_fail_out;
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency heat ignored");
  property p_fault_ind;
    demand && dd_fault_q |=> heat_fail_out && cool_fail_out;
  endproperty
  a_fault_ind: assert property (p_fault_ind) else $error("demand fault not shown");
  property p_aux_down;
    aux_q < $past(aux_q) |-> $past(sr_check) || !$past(mech);
  endproperty
  a_aux_down: assert property (p_aux_down) else $error("aux staged down off check");
  c_evap: cover property ($rose(evap_act_q));
  c_trip: cover property ($rose(trip_q));
  c_hp_defrost: cover property (hp_q == HP_IDLE ##1 hp_q == HP_DEFR);
  c_aux_up: cover property ($rose(aux_stage_out[0]));
endmodule // hvac_defrost_sequencer

//--- rtl/hvac_defrost_cfg.svh
/*
  Constants of the defrost and recovery sequencer: timing, temperature limits,
  register offsets and fields. Assumes a 100 MHz system clock and a
  one-second timebase derived from it.
*/
`ifndef HVAC_DEFROST_CFG_SVH
`define HVAC_DEFROST_CFG_SVH
// ****************************************************************
// Timebase
// ****************************************************************
`define CLK_PERIOD_NS 10
`define HALF_SEC_NS 500000000
`define SEC_PER_MIN 60
`define SEC_PER_HR 3600
// ****************************************************************
// Evaporator defrost and freeze protection
// ****************************************************************
`define AMB_SINGLE_F 55
`define AMB_DUAL_F 40
`define EVAP_RUN_MIN 10
`define EVAP_DEF_MIN 3
`define FRZ_DEB_S 5
`define FRZ_MIN_RUN_MIN 3
`define FRZ_SAT_S 60
// ****************************************************************
// Heat pump defrost and smart recovery
// ****************************************************************
`define DD_INIT_MIN 30
`define DD_ODT_MAX_F 52
`define DD_CT_MAX_F 33
`define DD_TERM_ADD_F 47
`define DD_MARGIN_F 4
`define DD_LOW_DELTA_F 2
`define DD_LOW_HR 2
`define DD_TIMED_MAX 10
`define DD_HIGH_MAX 16
`define DEF_MAX_MIN 10
`define FB_RUN_MIN 30
`define LINK_RUN_MIN 70
`define TT_SEL0_MIN 70
`define TT_SEL1_MIN 90
`define TT_SEL2_MIN 60
`define TT_SEL3_MIN 45
`define SOFT_S 5
`define SR_CHECK_MIN 9
`define SR_RISE_TENTHS 9
// ****************************************************************
// Registers
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_STAT 4'h1
`define CTRL_RST 8'h02
`define CTRL_AUX_F 1:0
`endif

//--- rtl/hvac_defrost_pkg.sv
/*
  Types shared by the sequencer files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hvac_defrost_pkg;
  // Heat pump defrost phases
  typedef enum logic [1:0] {HP_IDLE, HP_DEFR, HP_SOFT} hp_state_t;
endpackage

//--- rtl/hvac_timebase.sv
/*
  Divider giving half-second and one-second ticks off the system clock.
  Assumes reset_n_in asynchronous, active low.
*/
`timescale 1ns/1ns
`include "hvac_defrost_cfg.svh"
module hvac_timebase #(
  parameter int HALF_CYCLES = `HALF_SEC_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Ticks, one cycle each
  output logic half_tick_out,
  output logic sec_tick_out
);
  localparam int CW = $clog2(HALF_CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic phase_q;
  wire last = (cnt_q == CW'(HALF_CYCLES - 1));

  // Single divider so every timer shares one phase
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= '0;
      phase_q <= 1'b0;
      half_tick_out <= 1'b0;
      sec_tick_out <= 1'b0;
    end else begin
      cnt_q <= last ? '0 : cnt_q + 1'b1;
      phase_q <= phase_q ^ last;
      half_tick_out <= last;
      sec_tick_out <= last & phase_q;
    end
  end
endmodule // hvac_timebase

//--- tb/unit_model.sv
/*
  Far-side unit model: outdoor coil sensor and defrost temperature switch.
  Assumes the switchover valve output of the sequencer drives valve_in.
*/
`timescale 1ns/1ns
module unit_model (
  // Clock and valve
  input wire logic sys_clk_in,
  input wire logic valve_in,
  // Sensor and switch
  output logic signed [7:0] coil_temp_out,
  output logic defrost_temp_switch_out
);
  logic signed [7:0] coil_q = 8'sh14;
  // Coil warms in defrost and cools in heating; slow enough to span many cycles
  always @(posedge sys_clk_in) begin
    if (valve_in && coil_q < 8'sh3C) coil_q <= coil_q + 8'sh01;
    else if (!valve_in && coil_q > 8'sh14) coil_q <= coil_q - 8'sh01;
  end
  assign coil_temp_out = coil_q;
  // Switch closed while coil is cold, open once warm
  assign defrost_temp_switch_out = (coil_q < 8'sh28);
endmodule // unit_model

//--- tb/tb_top.sv
/*
  Testbench of the sequencer: registers, evaporator defrost, timed defrost
  with soft start, recovery staging, freeze trip, emergency heat, link loss.
  Assumes one second equals 10 cycles.
*/
`timescale 1ns/1ns
module tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic sys_clk_in = 1'b0, reset_n_in = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic frz = 1'b1, emerg = 1'b0, link = 1'b1, demand = 1'b0, dual = 1'b0;
  logic cool = 1'b0, heat = 1'b0, sfail = 1'b0, econ = 1'b0, ecn_o, ifan, ofan, valve, hfail, dts;
  logic sfan, cfail, hled;
  logic [1:0] sel = 2'h3, hp_open = 2'h0, req = 2'h0, comp, aux;
  logic signed [7:0] outdoor_temp = 8'sh1E, coil;
  logic signed [9:0] zone = 10'sh000;
  int n_mismatch = 0, comparisons = 0, n;
  wire [4:0] mon = {sfan, aux[0], ofan, valve, ifan};
  // Clock of 10 ns
  always #5 sys_clk_in = ~sys_clk_in;
  hvac_defrost_sequencer #(.HALF_CYCLES(5)) uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .freeze_closed_in(frz), .defrost_temp_switch_in(dts), .hp_ctrl_open_in(hp_open), .emerg_heat_in(emerg),
    .dfm_link_ok_in(link), .interval_sel_in(sel), .demand_cfg_in(demand), .dual_fan_cfg_in(dual),
    .cool_call_in(cool), .heat_call_in(heat), .comp_req_in(req), .outdoor_temp_in(outdoor_temp),
    .coil_temp_in(coil), .zone_temp_in(zone), .coil_sensor_fail_in(sfail),
    .outdoor_air_sensor_fail_in(sfail), .econ_cmd_in(econ), .comp_on_out(comp),
    .indoor_fan_force_out(ifan), .supply_fan_force_out(sfan), .outdoor_fan_on_out(ofan),
    .switchover_valve_out(valve), .aux_stage_out(aux), .econ_cmd_out(ecn_o), .heat_fail_out(hfail),
    .cool_fail_out(cfail), .heat_led_out(hled), .cool_led_out());
  unit_model far (.sys_clk_in(sys_clk_in), .valve_in(valve), .coil_temp_out(coil),
    .defrost_temp_switch_out(dts));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test();
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // Bounded wait for a monitored output; overrun ends the run
  task automatic wait_sig(input int s, input logic lvl, input int lim, output int k);
    k = 0;
    while (mon[s] !== lvl) begin
      @(posedge sys_clk_in);
      #1;
      k++;
      if (k > lim) begin
        n_mismatch++;
        end_of_test();
      end
    end
  endtask
  task automatic reg_rw(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge sys_clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic regs_after_reset();
    reg_rw(1'b0, 4'h0, 8'h00);
    check(rdata, 8'h02);
    check(comp, 2'h0);
    reg_rw(1'b0, 4'h9, 8'h00);
    check(rdata, 8'h00);
    reg_rw(1'b1, 4'h0, 8'h01);
    reg_rw(1'b0, 4'h0, 8'h00);
    check(rdata, 8'h01);
  endtask
  // Low-ambient cooling leads to a timed evaporator defrost
  task automatic evap_defrost();
    @(posedge sys_clk_in);
    cool <= 1'b1;
    req <= 2'h3;
    wait_sig(0, 1'b1, 6100, n);
    check(n >= 5900 && n <= 6030, 1);
    repeat (3) @(posedge sys_clk_in);
    econ <= 1'b1;
    #1;
    check(comp, 2'h0);
    @(posedge sys_clk_in);
    #1;
    check(ecn_o, 1'b1);
    reg_rw(1'b0, 4'h1, 8'h00);
    check(rdata, 8'h01);
    wait_sig(0, 1'b0, 1900, n);
    check(n >= 1770 && n <= 1830, 1);
    repeat (3) @(posedge sys_clk_in);
    #1;
    check(comp, 2'h3);
  endtask
  // Heating with the shortest interval, then soft start before the valve drops
  task automatic timed_defrost();
    @(posedge sys_clk_in);
    cool <= 1'b0;
    heat <= 1'b1;
    wait_sig(1, 1'b1, 27200, n);
    check(n >= 26900 && n <= 27100, 1);
    wait_sig(2, 1'b1, 200, n);
    check(valve, 1'b1);
    wait_sig(2, 1'b0, 70, n);
    check(n >= 40 && n <= 60, 1);
    repeat (2) @(posedge sys_clk_in);
    #1;
    check(valve, 1'b0);
    check(aux, 2'h1);
  endtask
  // Zone now rising: the single installed stage drops at the next check
  task automatic recovery();
    @(posedge sys_clk_in);
    zone <= 10'sh064;
    wait_sig(3, 1'b0, 5500, n);
    check(n <= 5420, 1);
  endtask
  // Freeze switch open trips; a late cooling call stretches the fan hold
  task automatic freeze_trip();
    @(posedge sys_clk_in);
    frz <= 1'b0;
    wait_sig(4, 1'b1, 80, n);
    check(n >= 45 && n <= 65, 1);
    repeat (2) @(posedge sys_clk_in);
    #1;
    check(comp, 2'h0);
    @(posedge sys_clk_in);
    frz <= 1'b1;
    cool <= 1'b1;
    @(posedge sys_clk_in);
    cool <= 1'b0;
    wait_sig(4, 1'b0, 700, n);
    check(n >= 585 && n <= 615, 1);
  endtask
  task automatic emergency_heat();
    @(posedge sys_clk_in);
    emerg <= 1'b1;
    repeat (10) @(posedge sys_clk_in);
    #1;
    check(hfail, 1'b1);
    check(comp, 2'h0);
    check(aux, 2'h1);
  endtask
  // Module link lost in timed mode: dual failure, indicators blink
  task automatic link_lost();
    logic seen;
    @(posedge sys_clk_in);
    emerg <= 1'b0;
    link <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    #1;
    check(cfail, 1'b1);
    seen = hled;
    repeat (5) @(posedge sys_clk_in);
    #1;
    check(hled ^ seen, 1'b1);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    regs_after_reset();
    evap_defrost();
    timed_defrost();
    recovery();
    freeze_trip();
    emergency_heat();
    link_lost();
    end_of_test();
  end
endmodule // tb_top
